// [omc_pkg.sv]
package omc_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 12;
   // bit positions of the serial control word and its mode-select codes
   localparam int CW_MS_LSB = 0;
   localparam int CW_WD_KEEP = 3;
   localparam int CW_LS_A = 4;
   localparam int CW_LS_B = 5;
   localparam int CW_LED = 6;
   localparam int CW_MEAS = 7;
   localparam int CW_MON = 8;
   localparam int CW_SUPPLY = 9;
   localparam logic [2:0] MS_ACTIVE = 3'h1;
   localparam logic [2:0] MS_LIN_SLEEP = 3'h2;
   localparam logic [2:0] MS_RX_ONLY = 3'h3;
   localparam logic [2:0] MS_STOP = 3'h4;
   localparam logic [2:0] MS_SLEEP = 3'h5;
   // apb byte offsets
   localparam logic [11:0] ADDR_MODE = 12'h000;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
   localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h008;
   localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h00c;
   localparam logic [11:0] ADDR_CTRL_WORD = 12'h010;
   // event bits
   localparam int NUM_EV = 4;
   localparam int EV_BUS_WAKE = 0;
   localparam int EV_MON_WAKE = 1;
   localparam int EV_WORD = 2;
   localparam int EV_MODE = 3;
   localparam logic [3:0] IRQ_EN_RST = 4'h0;
   localparam logic [15:0] CTRL_WORD_RST = 16'h0000;
   typedef enum logic [2:0] {
      OMC_STANDBY = 3'h0,
      OMC_ACTIVE = 3'h1,
      OMC_RX_ONLY = 3'h3,
      OMC_LIN_SLEEP = 3'h2,
      OMC_STOP = 3'h6,
      OMC_SLEEP = 3'h7
   } omc_mode_e;
endpackage : omc_pkg

// [omc_sync.sv]
`timescale 1ns/1ps
module omc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : omc_sync

// [omc_serial_rx.sv]
`timescale 1ns/1ps
module omc_serial_rx (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sclk_s,
   input wire logic sel_n_s,
   input wire logic sdi_s,
   output logic word_valid,
   output logic [omc_pkg::WORD_W-1:0] word
);
   logic sclk_d;
   logic sel_n_d;
   logic [omc_pkg::WORD_W-1:0] shreg;
   logic [4:0] bit_cnt;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sclk_d <= 1'b0;
         sel_n_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         sel_n_d <= sel_n_s;
      end
   end

   // lsb first, captured on the falling serial clock edge
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         shreg <= '0;
         bit_cnt <= 5'h00;
      end else if (sel_n_s) begin
         bit_cnt <= 5'h00;
      end else if (sclk_d && !sclk_s) begin
         shreg <= {sdi_s, shreg[omc_pkg::WORD_W-1:1]};
         if (bit_cnt != 5'h1f) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   // only a frame of exactly one word counts; short or long frames are dropped
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         word_valid <= 1'b0;
         word <= '0;
      end else begin
         word_valid <= 1'b0;
         if (sel_n_s && !sel_n_d && bit_cnt == 5'(omc_pkg::WORD_W)) begin
            word_valid <= 1'b1;
            word <= shreg;
         end
      end
   end
endmodule : omc_serial_rx

// [omc_mode_ctrl.sv]
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Behaviour
// - the three mode-select bits of the serial word pick Active, LIN Sleep, Receive-Only, Stop or Sleep operation.
// - after reset and after a wake-up from Stop or Sleep the block enters Standby on its own.
// - no mode-select code ever leads into Standby.
// - from Standby the block moves to whatever mode a serial command requests.
// - modes change only by a serial command or by a wake-up event.
// - monitor pins keep their previous state in Standby, Stop and Sleep, the supply output in Standby and Stop only (it is off in Sleep); both are off after reset.
// - in Stop the watchdog is off while regulator current is below its threshold.
// - the watchdog is off by default in Stop and Sleep and may be kept on by the host for periodic wake-ups.
// - in Active both LIN transmit and receive run and receive data follows the bus.
// - in LIN Sleep the transceiver and pull-up are off while bus wake detection stays on.
// - a bus wake in LIN Sleep drives receive data low and sets the bus wake flag.
// - after such a wake the transceiver stays off until the host selects Active or Receive-Only by command.
// - in Receive-Only the transmit stage is off and transmit data is ignored while the receiver runs.
// - each command is a 16-bit word sent lsb first and sampled on the falling serial clock edge.
module omc_mode_ctrl (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [omc_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_clk,
   input wire logic serial_sel_n,
   input wire logic serial_data_in,
   input wire logic lin_bus_wake,
   input wire logic lin_bus_level,
   input wire logic lin_tx_data,
   input wire logic mon_pin_level,
   input wire logic reg_current_low,
   output logic regulator_en,
   output logic window_watchdog_en,
   output logic low_side_switch_a,
   output logic low_side_switch_b,
   output logic high_side_led_driver,
   output logic supply_out_en,
   output logic monitor_pins_en,
   output logic lin_tx_en,
   output logic lin_tx_drive,
   output logic lin_rx_en,
   output logic lin_pullup_en,
   output logic lin_wake_det_en,
   output logic rxd,
   output logic meas_if_en,
   output logic adc_reference_output,
   output logic serial_port_en,
   output logic bus_wake_flag,
   output logic irq
);
   omc_pkg::omc_mode_e mode;
   omc_pkg::omc_mode_e next_mode;
   logic [6:0] pin_s;
   logic sclk_s, sel_n_s, sdi_s, lin_wake_s, lin_lvl_s, txd_s, mon_s, cur_low_s;
   logic mon_d;
   logic word_valid;
   logic [omc_pkg::WORD_W-1:0] rx_word;
   logic [omc_pkg::WORD_W-1:0] ctrl_word;
   logic word_take;
   logic wake_any;
   logic mon_wake;
   logic wake_low;
   logic mon_hold, supply_hold;
   logic [omc_pkg::NUM_EV-1:0] irq_status, irq_enable, ev;
   logic apb_wr, apb_rd;

   omc_sync #(.WIDTH(7)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in({serial_clk, serial_sel_n, serial_data_in, lin_bus_wake, lin_bus_level, lin_tx_data,
                 mon_pin_level}),
      .sync_out(pin_s)
   );
   assign {sclk_s, sel_n_s, sdi_s, lin_wake_s, lin_lvl_s, txd_s, mon_s} = pin_s;

   omc_sync #(.WIDTH(1)) u_sync_cur (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in(reg_current_low),
      .sync_out(cur_low_s)
   );

   omc_serial_rx u_rx (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sclk_s(sclk_s),
      .sel_n_s(sel_n_s),
      .sdi_s(sdi_s),
      .word_valid(word_valid),
      .word(rx_word)
   );

   function automatic logic is_active_family(input omc_pkg::omc_mode_e m);
      return m == omc_pkg::OMC_ACTIVE || m == omc_pkg::OMC_RX_ONLY || m == omc_pkg::OMC_LIN_SLEEP;
   endfunction : is_active_family

   // unknown codes keep the present mode, so no code can reach standby
   function automatic omc_pkg::omc_mode_e ms_decode(input logic [2:0] ms, input omc_pkg::omc_mode_e cur);
      unique case (ms)
         omc_pkg::MS_ACTIVE: return omc_pkg::OMC_ACTIVE;
         omc_pkg::MS_LIN_SLEEP: return omc_pkg::OMC_LIN_SLEEP;
         omc_pkg::MS_RX_ONLY: return omc_pkg::OMC_RX_ONLY;
         omc_pkg::MS_STOP: return omc_pkg::OMC_STOP;
         omc_pkg::MS_SLEEP: return omc_pkg::OMC_SLEEP;
         default: return cur;
      endcase
   endfunction : ms_decode

   // serial port is dead in sleep, so words are not taken there
   assign word_take = word_valid && mode != omc_pkg::OMC_SLEEP;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mon_d <= 1'b0;
      end else begin
         mon_d <= mon_s;
      end
   end
   assign mon_wake = mon_hold && (mon_s != mon_d);
   assign wake_any = lin_wake_s || mon_wake;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         omc_pkg::OMC_STOP, omc_pkg::OMC_SLEEP: begin
            // wake beats a command arriving in the same cycle
            if (wake_any) begin
               next_mode = omc_pkg::OMC_STANDBY;
            end else if (word_take) begin
               next_mode = ms_decode(rx_word[omc_pkg::CW_MS_LSB +: 3], mode);
            end
         end
         omc_pkg::OMC_STANDBY, omc_pkg::OMC_ACTIVE, omc_pkg::OMC_RX_ONLY, omc_pkg::OMC_LIN_SLEEP: begin
            if (word_take) begin
               next_mode = ms_decode(rx_word[omc_pkg::CW_MS_LSB +: 3], mode);
            end
         end
         default: next_mode = omc_pkg::OMC_STANDBY;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode <= omc_pkg::OMC_STANDBY;
      end else begin
         mode <= next_mode;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_word <= omc_pkg::CTRL_WORD_RST;
      end else if (word_take) begin
         ctrl_word <= rx_word;
      end
   end

   // monitor and supply states change only under host control in the active family
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mon_hold <= 1'b0;
         supply_hold <= 1'b0;
      end else if (word_take && is_active_family(next_mode)) begin
         mon_hold <= rx_word[omc_pkg::CW_MON];
         supply_hold <= rx_word[omc_pkg::CW_SUPPLY];
      end
   end

   // wake indication stays low until the host switches mode by command
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wake_low <= 1'b0;
      end else if (!is_active_family(mode) && wake_any) begin
         wake_low <= 1'b1;
      end else if (mode == omc_pkg::OMC_LIN_SLEEP && lin_wake_s) begin
         wake_low <= 1'b1;
      end else if (word_take && next_mode != mode) begin
         wake_low <= 1'b0;
      end
   end

   // cleared by the next accepted word, but a new wake wins
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_wake_flag <= 1'b0;
      end else if (lin_wake_s && mode != omc_pkg::OMC_ACTIVE && mode != omc_pkg::OMC_RX_ONLY) begin
         bus_wake_flag <= 1'b1;
      end else if (word_take) begin
         bus_wake_flag <= 1'b0;
      end
   end

   // outputs are registered from next_mode so they line up with mode
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         regulator_en <= 1'b1;
         serial_port_en <= 1'b1;
         window_watchdog_en <= 1'b1;
         low_side_switch_a <= 1'b0;
         low_side_switch_b <= 1'b0;
         high_side_led_driver <= 1'b0;
         meas_if_en <= 1'b0;
         adc_reference_output <= 1'b0;
         supply_out_en <= 1'b0;
         monitor_pins_en <= 1'b0;
         lin_tx_en <= 1'b0;
         lin_rx_en <= 1'b0;
         lin_pullup_en <= 1'b0;
         lin_wake_det_en <= 1'b1;
      end else begin
         regulator_en <= next_mode != omc_pkg::OMC_SLEEP;
         serial_port_en <= next_mode != omc_pkg::OMC_SLEEP;
         unique case (next_mode)
            omc_pkg::OMC_STOP: window_watchdog_en <= next_word_bit(omc_pkg::CW_WD_KEEP) || !cur_low_s;
            omc_pkg::OMC_SLEEP: window_watchdog_en <= next_word_bit(omc_pkg::CW_WD_KEEP);
            default: window_watchdog_en <= 1'b1;
         endcase
         low_side_switch_a <= is_active_family(next_mode) && next_word_bit(omc_pkg::CW_LS_A);
         low_side_switch_b <= is_active_family(next_mode) && next_word_bit(omc_pkg::CW_LS_B);
         high_side_led_driver <= is_active_family(next_mode) && next_word_bit(omc_pkg::CW_LED);
         meas_if_en <= is_active_family(next_mode) && next_word_bit(omc_pkg::CW_MEAS);
         adc_reference_output <= is_active_family(next_mode);
         supply_out_en <= next_supply() && next_mode != omc_pkg::OMC_SLEEP;
         monitor_pins_en <= next_mon();
         lin_tx_en <= next_mode == omc_pkg::OMC_ACTIVE;
         lin_rx_en <= next_mode == omc_pkg::OMC_ACTIVE || next_mode == omc_pkg::OMC_RX_ONLY;
         lin_pullup_en <= next_mode == omc_pkg::OMC_ACTIVE || next_mode == omc_pkg::OMC_RX_ONLY;
         lin_wake_det_en <= next_mode != omc_pkg::OMC_ACTIVE && next_mode != omc_pkg::OMC_RX_ONLY;
      end
   end

   function automatic logic next_word_bit(input int pos);
      return word_take ? rx_word[pos] : ctrl_word[pos];
   endfunction : next_word_bit

   function automatic logic next_supply();
      return (word_take && is_active_family(next_mode)) ? rx_word[omc_pkg::CW_SUPPLY] : supply_hold;
   endfunction : next_supply

   function automatic logic next_mon();
      return (word_take && is_active_family(next_mode)) ? rx_word[omc_pkg::CW_MON] : mon_hold;
   endfunction : next_mon

   // transmit data is passed only in full active mode
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lin_tx_drive <= 1'b1;
         rxd <= 1'b1;
      end else begin
         lin_tx_drive <= (mode == omc_pkg::OMC_ACTIVE) ? txd_s : 1'b1;
         if (mode == omc_pkg::OMC_ACTIVE || mode == omc_pkg::OMC_RX_ONLY) begin
            rxd <= lin_lvl_s;
         end else begin
            rxd <= !(wake_low || wake_any);
         end
      end
   end

   // interrupt events
   assign ev[omc_pkg::EV_BUS_WAKE] = lin_wake_s && lin_wake_det_en;
   assign ev[omc_pkg::EV_MON_WAKE] = mon_wake;
   assign ev[omc_pkg::EV_WORD] = word_take;
   assign ev[omc_pkg::EV_MODE] = next_mode != mode;

   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_status <= '0;
      end else begin
         // set wins over a clear in the same cycle
         irq_status <= (apb_wr && paddr == omc_pkg::ADDR_IRQ_CLEAR) ?
                       ((irq_status & ~pwdata[omc_pkg::NUM_EV-1:0]) | ev) : (irq_status | ev);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_enable <= omc_pkg::IRQ_EN_RST;
      end else if (apb_wr && paddr == omc_pkg::ADDR_IRQ_ENABLE) begin
         irq_enable <= pwdata[omc_pkg::NUM_EV-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   // zero-wait slave: read data is loaded in setup, pready held high
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            pslverr <= !(paddr == omc_pkg::ADDR_MODE || paddr == omc_pkg::ADDR_IRQ_STATUS ||
                         paddr == omc_pkg::ADDR_IRQ_CLEAR || paddr == omc_pkg::ADDR_IRQ_ENABLE ||
                         paddr == omc_pkg::ADDR_CTRL_WORD);
         end
         if (apb_rd) begin
            unique case (paddr)
               omc_pkg::ADDR_MODE: prdata <= {27'h0, bus_wake_flag, 1'b0, mode};
               omc_pkg::ADDR_IRQ_STATUS: prdata <= {28'h0, irq_status};
               omc_pkg::ADDR_IRQ_ENABLE: prdata <= {28'h0, irq_enable};
               omc_pkg::ADDR_CTRL_WORD: prdata <= {16'h0, ctrl_word};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_no_cmd_standby;
      (word_take && mode != omc_pkg::OMC_STANDBY && !wake_any) |=> mode != omc_pkg::OMC_STANDBY;
   endproperty
   a_no_cmd_standby: assert property (p_no_cmd_standby) else $error("command led to standby");

   property p_wake_standby;
      ((mode == omc_pkg::OMC_STOP || mode == omc_pkg::OMC_SLEEP) && wake_any) |=> mode == omc_pkg::OMC_STANDBY;
   endproperty
   a_wake_standby: assert property (p_wake_standby) else $error("wake did not reach standby");

   property p_active_lin;
      mode == omc_pkg::OMC_ACTIVE |-> lin_tx_en && lin_rx_en && !lin_wake_det_en;
   endproperty
   a_active_lin: assert property (p_active_lin) else $error("active lin enables wrong");

   property p_lin_sleep_off;
      mode == omc_pkg::OMC_LIN_SLEEP |-> !lin_tx_en && !lin_rx_en && !lin_pullup_en && lin_wake_det_en;
   endproperty
   a_lin_sleep_off: assert property (p_lin_sleep_off) else $error("lin sleep transceiver not off");

   property p_bus_wake;
      (mode == omc_pkg::OMC_LIN_SLEEP && lin_wake_s && !word_take) |=> bus_wake_flag ##1 !rxd;
   endproperty
   a_bus_wake: assert property (p_bus_wake) else $error("bus wake not flagged");

   property p_lin_sleep_stay;
      (mode == omc_pkg::OMC_LIN_SLEEP && !word_take) |=> mode == omc_pkg::OMC_LIN_SLEEP;
   endproperty
   a_lin_sleep_stay: assert property (p_lin_sleep_stay) else $error("left lin sleep without command");

   property p_rx_only;
      mode == omc_pkg::OMC_RX_ONLY |-> !lin_tx_en && lin_rx_en ##1 lin_tx_drive;
   endproperty
   a_rx_only: assert property (p_rx_only) else $error("transmit active in receive-only");

   property p_stop_wd;
      (mode == omc_pkg::OMC_STOP && $past(mode) == omc_pkg::OMC_STOP && $past(cur_low_s) &&
       !ctrl_word[omc_pkg::CW_WD_KEEP])
         |-> !window_watchdog_en;
   endproperty
   a_stop_wd: assert property (p_stop_wd) else $error("watchdog on in stop at low current");

   property p_sleep_off;
      mode == omc_pkg::OMC_SLEEP |-> !regulator_en && !serial_port_en && !low_side_switch_a && !supply_out_en;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("sleep left a supply on");

   property p_hold_mon;
      (mode == omc_pkg::OMC_STOP && $past(mode) == omc_pkg::OMC_STOP) |-> $stable(monitor_pins_en);
   endproperty
   a_hold_mon: assert property (p_hold_mon) else $error("monitor state changed in stop");
endmodule : omc_mode_ctrl

// [omc_host_model.sv]
`timescale 1ns/1ps
module omc_host_model (
   input wire logic core_clk,
   output logic serial_clk,
   output logic serial_sel_n,
   output logic serial_data_in
);
   // lines rest at their pull levels, and the clock only runs inside a frame
   initial begin
      serial_clk = 1'b0;
      serial_sel_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // data moves three cycles after a fall, so a bit never changes together with the edge that samples it
   task automatic send_word(input logic [15:0] w, input int nbits);
      @(posedge core_clk);
      serial_sel_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         repeat (3) @(posedge core_clk);
         serial_data_in <= w[i]; // lsb first
         @(posedge core_clk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge core_clk);
         serial_clk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      serial_sel_n <= 1'b1;
      serial_data_in <= 1'b0;
      repeat (16) @(posedge core_clk);
   endtask : send_word
endmodule : omc_host_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic serial_clk, serial_sel_n, serial_data_in;
   logic lin_bus_wake, lin_bus_level, lin_tx_data, mon_pin_level, reg_current_low;
   logic regulator_en, window_watchdog_en, low_side_switch_a, low_side_switch_b, high_side_led_driver;
   logic supply_out_en, monitor_pins_en, lin_tx_en, lin_tx_drive, lin_rx_en, lin_pullup_en;
   logic lin_wake_det_en, rxd, meas_if_en, adc_reference_output, serial_port_en, bus_wake_flag, irq;
   logic [15:0] outs;
   int error_cnt = 0;
   int checks = 0;
   assign outs = {regulator_en, window_watchdog_en, low_side_switch_a, low_side_switch_b, high_side_led_driver,
      supply_out_en, monitor_pins_en, lin_tx_en, lin_tx_drive, lin_rx_en, lin_pullup_en, lin_wake_det_en,
      rxd, meas_if_en, adc_reference_output, serial_port_en};
   omc_mode_ctrl i_dut (.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .serial_clk, .serial_sel_n, .serial_data_in, .lin_bus_wake, .lin_bus_level, .lin_tx_data,
      .mon_pin_level, .reg_current_low, .regulator_en, .window_watchdog_en, .low_side_switch_a,
      .low_side_switch_b, .high_side_led_driver, .supply_out_en, .monitor_pins_en, .lin_tx_en, .lin_tx_drive,
      .lin_rx_en, .lin_pullup_en, .lin_wake_det_en, .rxd, .meas_if_en, .adc_reference_output, .serial_port_en,
      .bus_wake_flag, .irq);
   omc_host_model i_host (.core_clk, .serial_clk, .serial_sel_n, .serial_data_in);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge core_clk);
      end
      if (n == 50) begin
         chk(32'h0, 32'h1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic settle;
      repeat (10) @(posedge core_clk);
   endtask : settle
   task automatic cmd(input logic [15:0] w);
      i_host.send_word(w, 16);
      settle();
   endtask : cmd
   task automatic mode_is(input logic [2:0] m);
      apb(1'b0, omc_pkg::ADDR_MODE, 32'h0);
      chk({29'h0, rd[2:0]}, {29'h0, m});
   endtask : mode_is
   task automatic wake;
      @(posedge core_clk);
      lin_bus_wake <= 1'b1;
      settle();
   endtask : wake
   task automatic unwake;
      @(posedge core_clk);
      lin_bus_wake <= 1'b0;
      settle();
   endtask : unwake
   task automatic t_reset;
      chk(outs, 16'hc099);
      mode_is(3'h0);
      apb(1'b0, omc_pkg::ADDR_IRQ_ENABLE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
   endtask : t_reset
   task automatic t_active;
      logic [2:0] bad[3] = '{3'h0, 3'h6, 3'h7};
      @(posedge core_clk);
      lin_tx_data <= 1'b1;
      cmd(16'h03d1);
      mode_is(3'h1);
      chk(outs, 16'hefe7);
      @(posedge core_clk);
      lin_bus_level <= 1'b1;
      lin_tx_data <= 1'b0;
      settle();
      chk(outs, 16'hef6f);
      for (int i = 0; i < 3; i++) begin
         cmd({13'h007a, bad[i]});
         mode_is(3'h1);
      end
      $display("test active done");
   endtask : t_active
   task automatic t_rx_only;
      cmd(16'h03d3);
      mode_is(3'h3);
      chk({lin_tx_en, lin_tx_drive, lin_rx_en, rxd, low_side_switch_a}, 5'h0f);
      @(posedge core_clk);
      lin_bus_level <= 1'b0;
      settle();
      chk(rxd, 1'b0);
      $display("test receive only done");
   endtask : t_rx_only
   task automatic t_lin_sleep;
      apb(1'b1, omc_pkg::ADDR_IRQ_ENABLE, 32'h1);
      apb(1'b0, omc_pkg::ADDR_IRQ_ENABLE, 32'h0);
      chk(rd, 32'h1);
      cmd(16'h03d2);
      chk({lin_tx_en, lin_rx_en, lin_pullup_en, lin_wake_det_en, irq}, 5'h02);
      wake();
      chk({rxd, bus_wake_flag, lin_tx_en, lin_rx_en, irq}, 5'h09);
      apb(1'b0, omc_pkg::ADDR_MODE, 32'h0);
      chk(rd[4:0], 5'h12);
      unwake();
      apb(1'b1, omc_pkg::ADDR_IRQ_CLEAR, 32'h1);
      settle();
      chk(irq, 1'b0);
      cmd(16'h03d1);
      chk({lin_tx_en, lin_rx_en, bus_wake_flag}, 3'h6);
      $display("test lin sleep done");
   endtask : t_lin_sleep
   task automatic t_stop;
      @(posedge core_clk);
      reg_current_low <= 1'b1;
      cmd(16'h03d4);
      mode_is(3'h6);
      chk(outs, 16'h8699);
      @(posedge core_clk);
      reg_current_low <= 1'b0;
      settle();
      chk(window_watchdog_en, 1'b1);
      wake();
      mode_is(3'h0);
      chk({rxd, supply_out_en, monitor_pins_en}, 3'h3);
      unwake();
      @(posedge core_clk);
      reg_current_low <= 1'b1;
      cmd(16'h03d1);
      cmd(16'h03dc);
      chk(window_watchdog_en, 1'b1);
      @(posedge core_clk);
      mon_pin_level <= 1'b1;
      settle();
      mode_is(3'h0);
      apb(1'b0, omc_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk({rd[3:0], rxd}, 5'h1e);
      $display("test stop done");
   endtask : t_stop
   task automatic t_sleep;
      cmd(16'h03d1);
      cmd(16'h03d5);
      mode_is(3'h7);
      chk(outs, 16'h0298);
      cmd(16'h03d1);
      mode_is(3'h7);
      wake();
      mode_is(3'h0);
      chk({regulator_en, serial_port_en, rxd}, 3'h6);
      unwake();
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_frame;
      i_host.send_word(16'h03d1, 15);
      settle();
      mode_is(3'h0);
      cmd(16'h03d1);
      mode_is(3'h1);
      apb(1'b0, omc_pkg::ADDR_CTRL_WORD, 32'h0);
      chk(rd, 32'h03d1);
      $display("test frame length done");
   endtask : t_frame
   initial begin
      #1000000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {lin_bus_wake, lin_bus_level, lin_tx_data, mon_pin_level, reg_current_low} = '0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset();
      t_active();
      t_rx_only();
      t_lin_sleep();
      t_stop();
      t_sleep();
      t_frame();
      give_verdict();
   end
endmodule : tb_top
